// file: core/bbd_pkg.sv
// package for the byte/bit instruction decoder: opcode fields, ops, flag masks
// assumes a single core instruction clock; no software-visible registers
package bbd_pkg;

  // =========================================
  // field positions
  localparam int OPC6_HI = 15;
  localparam int OPC6_LO = 10;
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  localparam int BITNO_HI = 11;
  localparam int BITNO_LO = 9;
  localparam int ZOFF_W = 7;
  localparam int LONG_ADDR_W = 20;
  localparam int FILE12_W = 12;

  // =========================================
  // opcode prefixes (bits 15:12)
  localparam logic [3:0] PFX_MISC = 4'h0;
  localparam logic [3:0] PFX_LOGIC = 4'h1;
  localparam logic [3:0] PFX_ADD = 4'h2;
  localparam logic [3:0] PFX_ROTC = 4'h3;
  localparam logic [3:0] PFX_ROTN = 4'h4;
  localparam logic [3:0] PFX_SUB = 4'h5;
  localparam logic [3:0] PFX_CMP = 4'h6;
  localparam logic [3:0] PFX_BTG = 4'h7;
  localparam logic [3:0] PFX_BSET = 4'h8;
  localparam logic [3:0] PFX_BCLR = 4'h9;
  localparam logic [3:0] PFX_BTSS = 4'ha;
  localparam logic [3:0] PFX_BTSC = 4'hb;
  localparam logic [3:0] PFX_MOVE = 4'hc;
  localparam logic [3:0] PFX_LONG = 4'he;
  localparam logic [3:0] PFX_WORD2 = 4'hf;

  // sub-opcode bits 11:10
  localparam logic [1:0] SUB_00 = 2'h0;
  localparam logic [1:0] SUB_01 = 2'h1;
  localparam logic [1:0] SUB_10 = 2'h2;
  localparam logic [1:0] SUB_11 = 2'h3;

  // first-word high byte of long jumps/calls (bits 15:8 with s masked)
  localparam logic [6:0] LONG_CALL_HI = 7'h76;
  localparam logic [7:0] LONG_GOTO_HI = 8'hef;

  // flag mask order: {c, dc, z, ov, n}
  localparam logic [4:0] FLG_NONE = 5'h00;
  localparam logic [4:0] FLG_ALL = 5'h1f;
  localparam logic [4:0] FLG_ZN = 5'h05;
  localparam logic [4:0] FLG_CZN = 5'h15;

  // cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_ADD = 5'h01,
    OP_ADDC = 5'h02,
    OP_INC = 5'h03,
    OP_DEC = 5'h04,
    OP_AND = 5'h05,
    OP_OR = 5'h06,
    OP_XOR = 5'h07,
    OP_COM = 5'h08,
    OP_CMP_EQ = 5'h09,
    OP_CMP_GT = 5'h0a,
    OP_CMP_LT = 5'h0b,
    OP_INC_SZ = 5'h0c,
    OP_DEC_SZ = 5'h0d,
    OP_RLC = 5'h0e,
    OP_RRC = 5'h0f,
    OP_RLN = 5'h10,
    OP_RRN = 5'h11,
    OP_SUBF = 5'h12,
    OP_SUBFB = 5'h13,
    OP_SUBWB = 5'h14,
    OP_MUL = 5'h15,
    OP_FILE_TO_FILE_MOVE = 5'h16,
    OP_BCLR = 5'h17,
    OP_BSET = 5'h18,
    OP_BTGL = 5'h19,
    OP_BTSC = 5'h1a,
    OP_BTSS = 5'h1b,
    OP_LONG = 5'h1c,
    OP_OTHER = 5'h1d
  } bbd_op_t;

  typedef enum logic [1:0] {
    ST_FIRST = 2'b00,
    ST_MOVE2 = 2'b01,
    ST_LONG2 = 2'b10,
    ST_SKIP = 2'b11
  } bbd_state_t;

endpackage

// file: core/bbd_decoder.sv
// byte- and bit-oriented instruction decoder for an 8-bit accumulator core
// assumes fetch presents one word per instruction cycle with instr_valid_i;
// the datapath returns the skip condition result in the same cycle
`timescale 1ns/10ps

// Notes on behaviour
// - byte ops: opcode 15:10, dest bit 9, bank bit 8, file address 7:0.
// - bank bit 0 selects access bank, 1 uses bank pointer.
// - file_to_file_move is two words, 12-bit source then 12-bit destination.
// - bit ops: opcode 15:12, bit number 11:9; clear, set, toggle in one cycle.
// - literal operand is the low byte of the word.
// - long call and jump assemble a 20-bit target from both words.
// - don't-care bits never influence decoding.
// - indexed forms take 7-bit source and destination offsets.
// - add, add with carry, increment, decrement update all five flags.
// - and, or, xor, complement update zero and negative only.
// - compare and skip on equal, greater or less; no flags.
// - skip instructions take one cycle, or two or three when taken.
// - increment or decrement and skip if zero; no flags.
// - rotates through carry update c,z,n; plain rotates update z,n.
// - three subtract forms update all five flags.
// - multiply accumulator by file, product to pair, no flags.
// - bit test skips on clear or set, no flags.
// - a word starting with four ones alone executes as no-operation.
module bbd_decoder
  import bbd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [7:0] bank_pointer_i,
  input wire logic skip_cond_i,
  output logic op_valid_o,
  output logic [4:0] alu_op_o,
  output logic dest_file_o,
  output logic [11:0] file_addr_o,
  output logic [11:0] dest_addr_o,
  output logic [2:0] bit_num_o,
  output logic [7:0] literal_o,
  output logic [6:0] src_offset_o,
  output logic [6:0] dst_offset_o,
  output logic [19:0] long_target_o,
  output logic [4:0] flag_mask_o,
  output logic product_write_o,
  output logic is_skip_o,
  output logic slot_nop_o,
  output logic [1:0] cycles_o
);

  // =========================================
  // state
  typedef struct packed {
    bbd_state_t st;
    // a taken skip still owes at least one no-op slot
    logic skip_pend;
    // low byte of a long target, waiting for its second word
    logic [19:0] long_lo;
    logic op_valid;
    logic [4:0] alu_op;
    logic dest_file;
    logic [11:0] file_addr;
    logic [11:0] dest_addr;
    logic [2:0] bit_num;
    logic [7:0] literal;
    logic [6:0] src_off;
    logic [6:0] dst_off;
    logic [19:0] long_target;
    logic [4:0] flag_mask;
    logic product_write;
    logic is_skip;
    logic slot_nop;
    logic [1:0] cycles;
  } bbd_regs_t;

  // one packed state word: its registered copy and its next value
  bbd_regs_t cur_reg;
  bbd_regs_t cur_next;

  // =========================================
  // helpers
  // access bank lives in bank 0 here; the upper access-bank split is a datapath matter
  function automatic logic [11:0] bank_addr(input logic a, input logic [7:0] bp,
                                            input logic [7:0] f);
    bank_addr = a ? {bp[3:0], f} : {4'h0, f};
  endfunction

  // first word of a long call (its s bit is a don't-care here) or a long jump
  function automatic logic is_long_first(input logic [15:0] w);
    is_long_first = (w[15:9] == LONG_CALL_HI) || (w[15:8] == LONG_GOTO_HI);
  endfunction

  // a skipped two-word pointer load is not seen here and costs one slot too few
  function automatic logic is_two_word(input logic [15:0] w);
    is_two_word = (w[15:12] == PFX_MOVE) || is_long_first(w);
  endfunction

  // =========================================
  // decode
  // the table classifies the word and the sequencer decides whether it counts, except multiply's product write, gated here on a valid first word
  always_comb
  begin
    logic [3:0] pfx;
    logic [1:0] sub;
    bbd_op_t op;
    logic [4:0] fm;
    logic skp;
    pfx = instr_i[15:12];
    sub = instr_i[11:10];
    op = OP_OTHER;
    fm = FLG_NONE;
    skp = 1'b0;
    cur_next = cur_reg;
    cur_next.op_valid = 1'b0;
    cur_next.product_write = 1'b0;
    cur_next.slot_nop = 1'b0;
    cur_next.is_skip = 1'b0;

    // =========================================
    // opcode table: fields are shared, only the operation, mask, skip flag and multiply's product write differ
    case (pfx)
      PFX_ADD:
      begin
        fm = FLG_ALL;
        case (sub)
          SUB_01: op = OP_ADD;
          SUB_00: op = OP_ADDC;
          SUB_10: op = OP_INC;
          default:
          begin
            op = OP_DEC_SZ;
            fm = FLG_NONE;
            skp = 1'b1;
          end
        endcase
      end
      PFX_LOGIC:
      begin
        fm = FLG_ZN;
        case (sub)
          SUB_01: op = OP_AND;
          SUB_00: op = OP_OR;
          SUB_10: op = OP_XOR;
          default: op = OP_COM;
        endcase
      end
      PFX_CMP:
      begin
        case (instr_i[11:9])
          3'h1: op = OP_CMP_EQ;
          3'h2: op = OP_CMP_GT;
          3'h0: op = OP_CMP_LT;
          // test, clear, negate and plain move forms are not this block's
          default: op = OP_OTHER;
        endcase
        skp = (instr_i[11:9] <= 3'h2);
      end
      PFX_ROTC:
      begin
        case (sub)
          SUB_01: op = OP_RLC;
          SUB_00: op = OP_RRC;
          SUB_11: op = OP_INC_SZ;
          default: op = OP_OTHER;
        endcase
        fm = (sub[1] == 1'b0) ? FLG_CZN : FLG_NONE;
        skp = (sub == SUB_11);
      end
      PFX_ROTN:
      begin
        case (sub)
          SUB_01: op = OP_RLN;
          SUB_00: op = OP_RRN;
          // 11da is left undecoded: no rule of this block covers it
          default: op = OP_OTHER;
        endcase
        fm = (sub[1] == 1'b0) ? FLG_ZN : FLG_NONE;
      end
      PFX_SUB:
      begin
        fm = FLG_ALL;
        case (sub)
          SUB_11: op = OP_SUBF;
          SUB_10: op = OP_SUBFB;
          SUB_01: op = OP_SUBWB;
          default:
          begin
            // 00da is the plain file move, which still touches zero and negative
            op = OP_OTHER;
            fm = FLG_ZN;
          end
        endcase
      end
      PFX_MISC:
      begin
        // other 0000 codes are control and literal forms handled elsewhere
        if (instr_i[11:9] == 3'h1)
        begin
          op = OP_MUL;
          cur_next.product_write = instr_valid_i && (cur_reg.st == ST_FIRST);
        end
        else if (sub == SUB_01)
        begin
          op = OP_DEC;
          fm = FLG_ALL;
        end
      end
      PFX_BCLR: op = OP_BCLR;
      PFX_BSET: op = OP_BSET;
      PFX_BTG: op = OP_BTGL;
      PFX_BTSC:
      begin
        op = OP_BTSC;
        skp = 1'b1;
      end
      PFX_BTSS:
      begin
        op = OP_BTSS;
        skp = 1'b1;
      end
      PFX_MOVE: op = OP_FILE_TO_FILE_MOVE;
      PFX_LONG:
      begin
        // other 1110 codes are branches and pointer loads, decoded elsewhere
        if (is_long_first(instr_i))
          op = OP_LONG;
      end
      PFX_WORD2: op = OP_NOP;
      default: op = OP_OTHER;
    endcase

    // =========================================
    // word sequencing: first words, second words and skipped slots
    if (instr_valid_i)
    begin
      case (cur_reg.st)
        ST_FIRST:
        begin
          cur_next.op_valid = 1'b1;
          cur_next.alu_op = op;
          cur_next.flag_mask = fm;
          cur_next.is_skip = skp;
          cur_next.dest_file = instr_i[DEST_BIT];
          cur_next.bit_num = instr_i[BITNO_HI:BITNO_LO];
          cur_next.literal = instr_i[7:0];
          cur_next.src_off = instr_i[ZOFF_W-1:0];
          cur_next.file_addr = bank_addr(instr_i[BANK_BIT], bank_pointer_i, instr_i[7:0]);
          cur_next.cycles = CYC_ONE;
          // the datapath's condition only means something on a skip word
          cur_next.skip_pend = skp && skip_cond_i;
          if (op == OP_FILE_TO_FILE_MOVE)
          begin
            // no slot yet: the datapath must see one result per two-word instruction
            cur_next.op_valid = 1'b0;
            cur_next.file_addr = instr_i[FILE12_W-1:0];
            cur_next.cycles = CYC_TWO;
            cur_next.st = ST_MOVE2;
          end
          else if (op == OP_LONG)
          begin
            cur_next.op_valid = 1'b0;
            cur_next.long_lo = {12'h000, instr_i[7:0]};
            cur_next.cycles = CYC_TWO;
            cur_next.st = ST_LONG2;
          end
          else if (skp && skip_cond_i)
            cur_next.st = ST_SKIP;
        end
        ST_MOVE2:
        begin
          // second word completes the move; bits 15:12 are four ones by contract
          cur_next.op_valid = 1'b1;
          cur_next.alu_op = OP_FILE_TO_FILE_MOVE;
          cur_next.flag_mask = FLG_NONE;
          cur_next.dest_addr = instr_i[FILE12_W-1:0];
          cur_next.dst_off = instr_i[ZOFF_W-1:0];
          cur_next.cycles = CYC_TWO;
          cur_next.st = ST_FIRST;
        end
        ST_LONG2:
        begin
          // second word carries the upper twelve bits of the target
          cur_next.op_valid = 1'b1;
          cur_next.alu_op = OP_LONG;
          cur_next.flag_mask = FLG_NONE;
          cur_next.long_target = {instr_i[11:0], cur_reg.long_lo[7:0]};
          cur_next.cycles = CYC_TWO;
          cur_next.st = ST_FIRST;
        end
        ST_SKIP:
        begin
          // skipped word is executed as a no-op; a two-word move or long call/jump target costs one more slot
          cur_next.op_valid = 1'b1;
          cur_next.alu_op = OP_NOP;
          cur_next.flag_mask = FLG_NONE;
          cur_next.slot_nop = 1'b1;
          if (cur_reg.skip_pend && is_two_word(instr_i))
          begin
            // stay: the second half of the skipped pair is one more no-op slot
            cur_next.cycles = CYC_THREE;
            cur_next.skip_pend = 1'b0;
          end
          else
          begin
            // a one-word target, or the tail of a two-word one
            cur_next.cycles = cur_reg.skip_pend ? CYC_TWO : CYC_THREE;
            cur_next.skip_pend = 1'b0;
            cur_next.st = ST_FIRST;
          end
        end
        default: cur_next.st = ST_FIRST;
      endcase
    end
  end

  // =========================================
  // register
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    // all-zero is ST_FIRST with every output low
    if (!resetn_i)
      cur_reg <= '0;
    else
      cur_reg <= cur_next;
  end

  // =========================================
  // outputs: each port is one field of the registered state
  assign op_valid_o = cur_reg.op_valid;
  assign alu_op_o = cur_reg.alu_op;
  assign dest_file_o = cur_reg.dest_file;
  assign file_addr_o = cur_reg.file_addr;
  assign dest_addr_o = cur_reg.dest_addr;
  assign bit_num_o = cur_reg.bit_num;
  assign literal_o = cur_reg.literal;
  assign src_offset_o = cur_reg.src_off;
  assign dst_offset_o = cur_reg.dst_off;
  assign long_target_o = cur_reg.long_target;
  assign flag_mask_o = cur_reg.flag_mask;
  assign product_write_o = cur_reg.product_write;
  assign is_skip_o = cur_reg.is_skip;
  assign slot_nop_o = cur_reg.slot_nop;
  assign cycles_o = cur_reg.cycles;

endmodule

// file: tb/bbd_fetch_model.sv
// fetch-side partner of the decoder: presents words and the skip result
// assumes the bench calls its tasks just after a falling clock edge
`timescale 1ns/10ps
module bbd_fetch_model (
  output logic instr_valid_o,
  output logic [15:0] instr_o,
  output logic skip_cond_o
);
  initial
  begin
    instr_valid_o = 1'b0;
    instr_o = 16'h0000;
    skip_cond_o = 1'b0;
  end
  task automatic issue(input logic [15:0] w, input logic c);
    instr_valid_o = 1'b1;
    instr_o = w;
    skip_cond_o = c;
  endtask
  // a released bus shows the inverse of its last word, never a stale copy
  task automatic release_bus();
    instr_valid_o = 1'b0;
    instr_o = ~instr_o;
    skip_cond_o = ~skip_cond_o;
  endtask
endmodule

// file: tb/bbd_decoder_assertions.sv
// port-level checks of the byte/bit decoder, bound to its top module
// assumes one clock domain and the asynchronous active-low reset
`timescale 1ns/10ps
module bbd_decoder_assertions
  import bbd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [7:0] bank_pointer_i,
  input wire logic skip_cond_i,
  input wire logic op_valid_o,
  input wire logic [4:0] alu_op_o,
  input wire logic dest_file_o,
  input wire logic [11:0] file_addr_o,
  input wire logic [11:0] dest_addr_o,
  input wire logic [2:0] bit_num_o,
  input wire logic [4:0] flag_mask_o,
  input wire logic product_write_o,
  input wire logic is_skip_o,
  input wire logic slot_nop_o,
  input wire logic [1:0] cycles_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // =========================================
  // sequences
  sequence took(logic [3:0] p);
    instr_valid_i && instr_i[15:12] == p ##1 op_valid_o && !slot_nop_o;
  endsequence
  sequence cmp_word;
    instr_valid_i && instr_i[15:12] == PFX_CMP && instr_i[11:9] inside {3'h0, 3'h1, 3'h2};
  endsequence
  sequence move_seq;
    instr_valid_i && instr_i[15:12] == PFX_MOVE
      ##1 !slot_nop_o && instr_valid_i && instr_i[15:12] == PFX_WORD2;
  endsequence
  // =========================================
  // properties
  idle_quiet_a: assert property (!instr_valid_i |=> !op_valid_o && !slot_nop_o)
    else $error("result slot without a fetched word");
  logic_dest_a: assert property (took(PFX_LOGIC) |->
    dest_file_o == $past(instr_i[9]) && flag_mask_o == FLG_ZN) else $error("logic op decode");
  bank_sel_a: assert property (took(PFX_SUB) |-> file_addr_o == ($past(instr_i[8]) ?
    {$past(bank_pointer_i[3:0]), $past(instr_i[7:0])} : {4'h0, $past(instr_i[7:0])}))
    else $error("banked address wrong");
  add_mask_a: assert property (instr_valid_i && instr_i[15:12] == PFX_ADD &&
    instr_i[11:10] != SUB_11 ##1 op_valid_o && !slot_nop_o |-> flag_mask_o == FLG_ALL)
    else $error("add mask");
  bit_num_a: assert property (took(PFX_BSET) |->
    bit_num_o == $past(instr_i[11:9]) && flag_mask_o == FLG_NONE) else $error("bit field");
  mul_prod_a: assert property (instr_valid_i && instr_i[15:9] == 7'h01 ##1
    op_valid_o && !slot_nop_o |-> product_write_o && flag_mask_o == FLG_NONE)
    else $error("multiply decode");
  move_pair_a: assert property (move_seq |=> op_valid_o && alu_op_o == OP_FILE_TO_FILE_MOVE &&
    dest_addr_o == $past(instr_i[11:0]) && file_addr_o == $past(instr_i[11:0], 2))
    else $error("move pair decode");
  skip_two_a: assert property (cmp_word ##0 skip_cond_i ##1 !slot_nop_o &&
    instr_valid_i && instr_i[15:12] inside {[4'h1:4'h9]} |=> slot_nop_o && cycles_o == CYC_TWO)
    else $error("taken skip cost");
  no_skip_a: assert property (cmp_word ##0 !skip_cond_i ##1 !slot_nop_o |->
    is_skip_o && cycles_o == CYC_ONE ##1 !slot_nop_o) else $error("untaken skip");
endmodule
bind bbd_decoder bbd_decoder_assertions bbd_decoder_assertions_inst (.mclk_i, .resetn_i,
  .instr_valid_i, .instr_i, .bank_pointer_i, .skip_cond_i, .op_valid_o, .alu_op_o,
  .dest_file_o, .file_addr_o, .dest_addr_o, .bit_num_o, .flag_mask_o, .product_write_o,
  .is_skip_o, .slot_nop_o, .cycles_o);

// file: tb/tb_byte_bit_instruction_decoder.sv
// self-checking bench of the byte/bit decoder with a fetch-side model
// assumes the decoder answers one cycle after each completed instruction
`timescale 1ns/10ps
`define CHK(a, e) \
  begin \
    comparisons++; \
    if ((a) !== (e)) \
    begin \
      n_mismatch++; \
      $display("[ERR] %0t got %h expected %h", $time, (a), (e)); \
    end \
  end
module tb_byte_bit_instruction_decoder
  import bbd_pkg::*;
;
  typedef struct packed {
    logic nop; logic [4:0] op; logic [4:0] msk; logic [1:0] cyc;
    logic [11:0] adr; logic [2:0] sel; logic [19:0] aux;
  } bbd_note_t;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] bank_pointer_i = 8'h00;
  logic instr_valid_i, skip_cond_i, op_valid_o, dest_file_o, product_write_o, is_skip_o;
  logic slot_nop_o;
  logic [15:0] instr_i, w;
  logic [4:0] alu_op_o, flag_mask_o;
  logic [11:0] file_addr_o, dest_addr_o, a;
  logic [2:0] bit_num_o;
  logic [7:0] literal_o;
  logic [6:0] src_offset_o, dst_offset_o;
  logic [19:0] long_target_o;
  logic [1:0] cycles_o;
  logic [17:0] e;
  logic d;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [31:0] lfsr = 32'hedcd48da;
  bbd_note_t notes[$];
  bbd_note_t nt;
  // {prefix, sub, fixed d (bit1 set = fixed), op, flag mask}
  logic [17:0] tbl [21] = '{{4'h2, 2'h1, 2'h0, OP_ADD, FLG_ALL}, {4'h2, 2'h0, 2'h0, OP_ADDC, FLG_ALL},
    {4'h2, 2'h2, 2'h0, OP_INC, FLG_ALL}, {4'h0, 2'h1, 2'h0, OP_DEC, FLG_ALL},
    {4'h1, 2'h1, 2'h0, OP_AND, FLG_ZN}, {4'h1, 2'h0, 2'h0, OP_OR, FLG_ZN},
    {4'h1, 2'h2, 2'h0, OP_XOR, FLG_ZN}, {4'h1, 2'h3, 2'h0, OP_COM, FLG_ZN},
    {4'h6, 2'h0, 2'h3, OP_CMP_EQ, FLG_NONE}, {4'h6, 2'h1, 2'h2, OP_CMP_GT, FLG_NONE},
    {4'h6, 2'h0, 2'h2, OP_CMP_LT, FLG_NONE}, {4'h3, 2'h3, 2'h0, OP_INC_SZ, FLG_NONE},
    {4'h2, 2'h3, 2'h0, OP_DEC_SZ, FLG_NONE}, {4'h3, 2'h1, 2'h0, OP_RLC, FLG_CZN},
    {4'h3, 2'h0, 2'h0, OP_RRC, FLG_CZN}, {4'h4, 2'h1, 2'h0, OP_RLN, FLG_ZN},
    {4'h4, 2'h0, 2'h0, OP_RRN, FLG_ZN}, {4'h5, 2'h3, 2'h0, OP_SUBF, FLG_ALL},
    {4'h5, 2'h2, 2'h0, OP_SUBFB, FLG_ALL}, {4'h5, 2'h1, 2'h0, OP_SUBWB, FLG_ALL},
    {4'h0, 2'h0, 2'h3, OP_MUL, FLG_NONE}};
  logic [3:0] bpfx [5] = '{PFX_BTG, PFX_BSET, PFX_BCLR, PFX_BTSS, PFX_BTSC};
  logic [4:0] bop [5] = '{OP_BTGL, OP_BSET, OP_BCLR, OP_BTSS, OP_BTSC};

  always #10 mclk_i = ~mclk_i;

  bbd_fetch_model bbd_fetch_model_inst (.instr_valid_o(instr_valid_i), .instr_o(instr_i),
    .skip_cond_o(skip_cond_i));
  bbd_decoder bbd_decoder_inst (.mclk_i, .resetn_i, .instr_valid_i, .instr_i, .bank_pointer_i,
    .skip_cond_i, .op_valid_o, .alu_op_o, .dest_file_o, .file_addr_o, .dest_addr_o, .bit_num_o,
    .literal_o, .src_offset_o, .dst_offset_o, .long_target_o, .flag_mask_o, .product_write_o,
    .is_skip_o, .slot_nop_o, .cycles_o);

  function automatic bbd_note_t mk(logic n, logic [4:0] o, logic [4:0] m, logic [1:0] c,
    logic [11:0] ad, logic [2:0] s, logic [19:0] x);
    return '{n, o, m, c, ad, s, x};
  endfunction
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // =========================================
  // driving, draining and closing
  task automatic send(input logic [15:0] wd, input logic c, input logic [7:0] b, bbd_note_t n);
    @(negedge mclk_i);
    bank_pointer_i = b;
    bbd_fetch_model_inst.issue(wd, c);
    if (n.cyc != 2'h0)
      notes.push_back(n);
  endtask
  task automatic drain();
    @(negedge mclk_i);
    bbd_fetch_model_inst.release_bus();
    for (int i = 0; i < 8 && notes.size() != 0; i++)
      @(negedge mclk_i);
    if (notes.size() != 0)
    begin
      n_mismatch++;
      $display("[ERR] %0t results missing", $time);
      complete_run();
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // =========================================
  // result monitor: oldest note against each result slot
  always @(negedge mclk_i)
    if (resetn_i && (op_valid_o === 1'b1 || slot_nop_o === 1'b1))
    begin
      `CHK(notes.size() != 0, 1'b1)
      nt = notes.pop_front();
      `CHK(slot_nop_o, nt.nop)
      `CHK(cycles_o, nt.cyc)
      if (!nt.nop)
      begin
        `CHK(alu_op_o, nt.op)
        `CHK(flag_mask_o, nt.msk)
        `CHK(product_write_o, (nt.op == OP_MUL))
        `CHK(is_skip_o, (nt.op inside {[OP_CMP_EQ:OP_DEC_SZ], OP_BTSC, OP_BTSS}))
        if (nt.sel inside {3'h1, 3'h2})
          `CHK(file_addr_o, nt.adr)
        if (nt.sel == 3'h1 && nt.aux[1])
          `CHK(dest_file_o, nt.aux[0])
        if (nt.sel == 3'h1)
          `CHK({literal_o, src_offset_o}, {nt.adr[7:0], nt.adr[6:0]})
        if (nt.sel == 3'h2)
          `CHK(bit_num_o, nt.aux[2:0])
        if (nt.sel == 3'h3)
          `CHK({file_addr_o, dest_addr_o, dst_offset_o}, {nt.adr, nt.aux[11:0], nt.aux[6:0]})
        if (nt.sel == 3'h4)
          `CHK(long_target_o, nt.aux)
      end
    end

  initial
  begin
    repeat (2) @(negedge mclk_i);
    resetn_i = 1'b1;
    // every byte code twice, in two passes through the table, skip result random on non-skip codes
    for (int k = 0; k < 42; k++)
    begin
      e = tbl[k % 21];
      lfsr = lfsr_next(lfsr);
      d = e[11] ? e[10] : lfsr[9];
      a = lfsr[8] ? {lfsr[19:16], lfsr[7:0]} : {4'h0, lfsr[7:0]};
      send({e[17:12], d, lfsr[8:0]}, (e[9:5] inside {[OP_CMP_EQ:OP_DEC_SZ]}) ? 1'b0 : lfsr[30],
        lfsr[23:16], mk(1'b0, e[9:5], e[4:0], CYC_ONE, a, 3'h1, {18'h0, !e[11], d}));
    end
    for (int k = 0; k < 10; k++)
    begin
      lfsr = lfsr_next(lfsr);
      a = lfsr[8] ? {lfsr[19:16], lfsr[7:0]} : {4'h0, lfsr[7:0]};
      send({bpfx[k % 5], lfsr[11:0]}, 1'b0, lfsr[23:16],
        mk(1'b0, bop[k % 5], FLG_NONE, CYC_ONE, a, 3'h2, {17'h0, lfsr[11:9]}));
    end
    lfsr = lfsr_next(lfsr);
    send({PFX_MOVE, lfsr[11:0]}, lfsr[31], lfsr[23:16], '0);
    send({PFX_WORD2, lfsr[27:16]}, lfsr[30], lfsr[7:0],
      mk(1'b0, OP_FILE_TO_FILE_MOVE, FLG_NONE, CYC_TWO, lfsr[11:0], 3'h3, {8'h0, lfsr[27:16]}));
    for (int j = 0; j < 2; j++)
    begin
      lfsr = lfsr_next(lfsr);
      w = {(j == 0) ? LONG_GOTO_HI : {LONG_CALL_HI, lfsr[12]}, lfsr[7:0]};
      send(w, lfsr[29], lfsr[23:16], '0);
      send({PFX_WORD2, lfsr[27:16]}, lfsr[28], lfsr[15:8],
        mk(1'b0, OP_LONG, FLG_NONE, CYC_TWO, 12'h000, 3'h4, {lfsr[27:16], lfsr[7:0]}));
    end
    // lone second word with arbitrary don't-care bits runs as a no-op
    send({PFX_WORD2, lfsr[13:2]}, lfsr[1], lfsr[31:24], mk(1'b0, OP_NOP, FLG_NONE, CYC_ONE,
      12'h000, 3'h0, 20'h0));
    drain();
    // taken skips over one and two words, then an untaken one
    send({PFX_CMP, 3'h1, lfsr[8:0]}, 1'b1, lfsr[23:16], mk(1'b0, OP_CMP_EQ, FLG_NONE, CYC_ONE,
      12'h000, 3'h0, 20'h0));
    send({PFX_LOGIC, lfsr[21:10]}, 1'b0, lfsr[7:0], mk(1'b1, 5'h0, 5'h0, CYC_TWO, 12'h0, 3'h0,
      20'h0));
    send({PFX_BTSS, lfsr[11:0]}, 1'b1, lfsr[7:0], mk(1'b0, OP_BTSS, FLG_NONE, CYC_ONE, 12'h0,
      3'h0, 20'h0));
    send({PFX_MOVE, lfsr[24:13]}, 1'b0, lfsr[7:0], mk(1'b1, 5'h0, 5'h0, CYC_THREE, 12'h0, 3'h0,
      20'h0));
    send({PFX_WORD2, lfsr[11:0]}, 1'b0, lfsr[7:0], mk(1'b1, 5'h0, 5'h0, CYC_THREE, 12'h0, 3'h0,
      20'h0));
    send({PFX_ADD, 2'h3, lfsr[9:0]}, 1'b0, lfsr[7:0], mk(1'b0, OP_DEC_SZ, FLG_NONE, CYC_ONE,
      12'h0, 3'h0, 20'h0));
    send({PFX_LOGIC, 2'h1, lfsr[9:0]}, 1'b1, lfsr[7:0], mk(1'b0, OP_AND, FLG_ZN, CYC_ONE, 12'h0,
      3'h0, 20'h0));
    drain();
    complete_run();
  end
endmodule
